// ---- src/usm_pkg.sv ----
// Shared constants and types for the four-mode serial port.
// Assumes a single system clock; every user of it imports usm_pkg::*.
package usm_pkg;

  // ==========================================================
  // Register map (byte addresses on the bus)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_BRG = 8'h10;

  // ==========================================================
  // Control field positions
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MODE_HI = 1;
  localparam int CTRL_DOUBLE = 2;
  localparam int CTRL_GENSEL = 3;
  localparam int CTRL_RXEN = 4;

  // Status field positions
  localparam int STAT_RXVALID = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_FRAMING = 2;
  localparam int STAT_TXFULL = 3;
  localparam int STAT_TXIDLE = 4;

  // ==========================================================
  // Reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [9:0] BRG_RESET = 10'h000;

  // ==========================================================
  // Mode codes from the two mode-select bits
  localparam logic [1:0] MODE_SHIFT = 2'b00;
  localparam logic [1:0] MODE_UART8 = 2'b01;
  localparam logic [1:0] MODE_UART9_FIX = 2'b10;
  localparam logic [1:0] MODE_UART9_VAR = 2'b11;

  // ==========================================================
  // Timing counts: shift divider in oscillator cycles, enables per bit, bits per frame
  localparam int SHIFT_DIV = 6;
  localparam int SHIFT_HALF = SHIFT_DIV / 2;
  localparam int OVERSAMPLE = 16;
  localparam int FRAME_BITS_8 = 10;
  localparam int FRAME_BITS_9 = 11;

  // ==========================================================
  // Control bits travel together
  typedef struct packed {
    logic rx_enable;
    logic rate_generator_select;
    logic rate_doubling_bit;
    logic mode_select_high;
    logic mode_select_low;
  } usm_ctrl_t;

  // Received word with its error flag
  typedef struct packed {
    logic framing_err;
    logic [8:0] data;
  } usm_rxword_t;

endpackage

// ---- src/usm_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module usm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  import usm_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH]; // Word array
  logic [AW-1:0] wr_q; // Write pointer
  logic [AW-1:0] rd_q; // Read pointer
  logic [AW:0] cnt_q; // Fill level, one bit wider for full
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // Honest flags from the fill level
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];

  // Pointer and level update
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      // Pointers wrap at DEPTH, which need not be a power of two
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Data store needs no reset
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= i_in_data;
  end

endmodule

// ---- src/usm_baud.sv ----
// Rate enables for the serial port: 16x oversampling and shift-mode half bits.
// Assumes the timer 1 overflow pulse comes from logic on the same clock.
`timescale 1ns/1ps
module usm_baud (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Configuration
  input wire usm_pkg::usm_ctrl_t i_ctrl,
  input wire logic [9:0] i_brg_reload,
  // External rate source
  input wire logic i_t1_ovf,
  // Enables out
  output logic o_tick16,
  output logic o_tick_half
);
  import usm_pkg::*;

  // ==========================================================
  // State
  logic [9:0] brg_q; // Dedicated generator counter
  logic half_q; // Divide-by-two when doubling is off
  logic [2:0] sh_q; // Shift-mode half-bit divider
  wire mode_fix = i_ctrl.mode_select_high && !i_ctrl.mode_select_low;
  wire brg_ovf = (brg_q == i_brg_reload);
  wire raw_tick;

  // Source choice: fixed oscillator, generator or timer 1
  assign raw_tick = mode_fix ? 1'b1 :
                    i_ctrl.rate_generator_select ? brg_ovf :
                    i_t1_ovf;
  // Doubling bit skips the final divide by two
  assign o_tick16 = raw_tick && (i_ctrl.rate_doubling_bit || half_q);
  assign o_tick_half = (sh_q == 3'(SHIFT_HALF - 1));

  // Counters
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      brg_q <= '0;
      half_q <= 1'b0;
      sh_q <= '0;
    end
    else
    begin
      // Generator overflows every reload+1 cycles
      brg_q <= brg_ovf ? '0 : brg_q + 1'b1;
      if (raw_tick)
        half_q <= !half_q;
      sh_q <= o_tick_half ? '0 : sh_q + 1'b1;
    end
  end

endmodule

// ---- src/usm_serial_port.sv ----
// Four-mode serial port with a classic Wishbone register slave.
// Assumes rxd comes from a pin (synchronised here) and timer 1 is on i_clk_sys.
//
// Notes on behaviour
// - Two mode bits select four modes
// - Transmit and receive run independently, simultaneously; in shift mode the one engine does one direction at a time
// - Shift mode: data on rxd, clock on txd
// - Shift mode bit rate is oscillator over six
// - 8-bit UART frame is ten bits
// - Fixed 9-bit UART frame is eleven bits
// - Variable 9-bit mode: same frame, variable rate
// - Async rate clock is sixteen times bit
// - Timer 1 source: doubled overflow over 32
// - Generator source: doubled oscillator over generator
// - Fixed mode: oscillator over 32 or 16
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module usm_serial_port #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Rate source
  input wire logic i_t1_ovf,
  // Serial pins
  input wire logic i_rxd,
  output logic o_rxd,
  output logic o_rxd_oe,
  output logic o_txd
);
  import usm_pkg::*;

  // ==========================================================
  // Registers and synchroniser
  usm_ctrl_t ctrl_q; // Software control
  logic [9:0] brg_q; // Generator reload
  logic [2:0] rxd_sync_q; // Two-stage sync plus edge history
  logic ack_q;
  logic [31:0] rdat_q;
  usm_rxword_t rx_hold_q; // Holding register for one word
  logic rx_valid_q;
  logic overrun_q;
  logic tick16;
  logic tick_half;
  wire rxd_s = rxd_sync_q[1];
  wire [1:0] mode = {ctrl_q.mode_select_high, ctrl_q.mode_select_low};
  wire is_shift = (mode == MODE_SHIFT);
  wire is_nine = (mode == MODE_UART9_FIX) || (mode == MODE_UART9_VAR);

  // ==========================================================
  // Bus decode
  wire req = i_wb_cyc && i_wb_stb && !ack_q;
  wire hit_ctrl = (i_wb_adr == REG_CTRL);
  wire hit_stat = (i_wb_adr == REG_STATUS);
  wire hit_tx = (i_wb_adr == REG_TXDATA);
  wire hit_rx = (i_wb_adr == REG_RXDATA);
  wire hit_brg = (i_wb_adr == REG_BRG);
  wire tx_in_ready;
  // A full FIFO holds the bus cycle until a word drains
  wire tx_push = req && i_wb_we && hit_tx && i_wb_sel[0];
  wire stall = tx_push && !tx_in_ready;
  wire take = req && !stall;
  wire wr_lo = take && i_wb_we && i_wb_sel[0];
  wire wr_hi = take && i_wb_we && i_wb_sel[1];
  wire rx_pop = take && !i_wb_we && hit_rx;
  wire stat_clr_ovr = wr_lo && hit_stat && i_wb_dat[STAT_OVERRUN];
  wire stat_clr_fe = wr_lo && hit_stat && i_wb_dat[STAT_FRAMING];

  // ==========================================================
  // Transmit FIFO and rate enables
  logic tx_out_valid;
  logic [8:0] tx_out_data;
  logic tx_take;
  logic tx_busy_q; // Async transmitter active
  logic s0_busy_q; // Shift engine active

  usm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_in_valid(tx_push),
    .o_in_ready(tx_in_ready),
    .i_in_data(i_wb_dat[8:0]),
    .o_out_valid(tx_out_valid),
    .i_out_ready(tx_take),
    .o_out_data(tx_out_data)
  );

  usm_baud u_baud (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_ctrl(ctrl_q),
    .i_brg_reload(brg_q),
    .i_t1_ovf(i_t1_ovf),
    .o_tick16(tick16),
    .o_tick_half(tick_half)
  );

  // ==========================================================
  // Read mux
  wire [31:0] stat_word = {27'h0, !tx_out_valid && !tx_busy_q && !s0_busy_q,
    !tx_in_ready, rx_hold_q.framing_err, overrun_q, rx_valid_q};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                       hit_stat ? stat_word :
                       hit_rx ? {23'h0, rx_hold_q.data} :
                       hit_brg ? {22'h0, brg_q} : 32'h0000_0000;

  // Bus slave: one-cycle registered answer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
      brg_q <= BRG_RESET;
    end
    else
    begin
      ack_q <= take;
      if (take && !i_wb_we)
        rdat_q <= rd_mux;
      if (wr_lo && hit_ctrl)
        ctrl_q <= i_wb_dat[4:0];
      if (wr_lo && hit_brg)
        brg_q[7:0] <= i_wb_dat[7:0];
      if (wr_hi && hit_brg)
        brg_q[9:8] <= i_wb_dat[9:8];
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // Pin synchroniser; only stage two and later are read
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      rxd_sync_q <= 3'b111;
    else
      rxd_sync_q <= {rxd_sync_q[1:0], i_rxd};
  end

  // ==========================================================
  // Asynchronous transmitter
  logic [10:0] tx_sh_q; // Frame shifter, bit 0 on the line
  logic [3:0] tx_bits_q; // Bits still to send
  logic [3:0] tx_sub_q; // Oversample phase
  wire tx_start = !is_shift && !tx_busy_q && tx_out_valid;
  // Ninth bit comes from the word; 8-bit mode sends a one there as its stop bit
  wire tx_b8 = is_nine ? tx_out_data[8] : 1'b1;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_bits_q <= '0;
      tx_sub_q <= '0;
    end
    else if (tx_start)
    begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= {1'b1, tx_b8, tx_out_data[7:0], 1'b0};
      tx_bits_q <= is_nine ? 4'(FRAME_BITS_9) : 4'(FRAME_BITS_8);
      tx_sub_q <= '0;
    end
    else if (tx_busy_q && tick16)
    begin
      tx_sub_q <= tx_sub_q + 1'b1;
      // Bit boundary after sixteen enables
      if (tx_sub_q == 4'(OVERSAMPLE - 1))
      begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 1'b1;
        if (tx_bits_q == 4'd1)
          tx_busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Asynchronous receiver
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} usm_rx_state_t;
  usm_rx_state_t rx_st_q;
  logic [9:0] rx_sh_q; // Shift in at the top
  logic [3:0] rx_cnt_q; // Bits sampled
  logic [3:0] rx_sub_q;
  logic arx_done;
  usm_rxword_t arx_word;
  wire [3:0] rx_need = is_nine ? 4'(FRAME_BITS_9 - 1) : 4'(FRAME_BITS_8 - 1);
  wire rx_fall = rxd_sync_q[2] && !rxd_s;
  wire [9:0] rx_next = {rxd_s, rx_sh_q[9:1]};
  wire rx_mid = (rx_sub_q == 4'(OVERSAMPLE / 2 - 1));
  wire rx_edge = (rx_sub_q == 4'(OVERSAMPLE - 1));

  // Frame contents: 8-bit mode reports stop as bit 8
  assign arx_done = (rx_st_q == RX_DATA) && tick16 && rx_edge && (rx_cnt_q == rx_need - 1'b1);
  assign arx_word.framing_err = !rx_next[9];
  assign arx_word.data = is_nine ? rx_next[8:0] : {rx_next[9], rx_next[8:1]};

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
      rx_sub_q <= '0;
    end
    else
    begin
      case (rx_st_q)
        RX_IDLE:
        begin
          // Start is a high-to-low transition
          if (!is_shift && ctrl_q.rx_enable && rx_fall)
          begin
            rx_st_q <= RX_START;
            rx_sub_q <= '0;
          end
        end
        RX_START:
        begin
          if (tick16)
          begin
            rx_sub_q <= rx_sub_q + 1'b1;
            // Mid start bit: a glitch back high is dropped
            if (rx_mid)
            begin
              rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
              rx_sub_q <= '0;
              rx_cnt_q <= '0;
            end
          end
        end
        RX_DATA:
        begin
          if (tick16)
          begin
            rx_sub_q <= rx_sub_q + 1'b1;
            // Sixteen enables on from mid start is mid bit
            if (rx_edge)
            begin
              rx_sh_q <= rx_next;
              rx_cnt_q <= rx_cnt_q + 1'b1;
              if (arx_done)
                rx_st_q <= RX_IDLE;
            end
          end
        end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Shift-register mode engine
  logic s0_tx_q; // Direction of current transfer
  logic s0_clk_q; // Shift clock, idles high
  logic [7:0] s0_sh_q;
  logic [2:0] s0_cnt_q;
  // Receive only runs when the holding register is free
  wire s0_tx_go = is_shift && !s0_busy_q && tx_out_valid;
  wire s0_rx_go = is_shift && !s0_busy_q && !tx_out_valid && ctrl_q.rx_enable && !rx_valid_q;
  wire s0_rise = s0_busy_q && tick_half && !s0_clk_q;
  wire s0_done = s0_rise && (s0_cnt_q == 3'd7);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      s0_busy_q <= 1'b0;
      s0_tx_q <= 1'b0;
      s0_clk_q <= 1'b1;
      s0_sh_q <= '1;
      s0_cnt_q <= '0;
    end
    else if (s0_tx_go || s0_rx_go)
    begin
      s0_busy_q <= 1'b1;
      s0_tx_q <= s0_tx_go;
      s0_sh_q <= s0_tx_go ? tx_out_data[7:0] : 8'hFF;
      s0_cnt_q <= '0;
    end
    else if (s0_busy_q && tick_half)
    begin
      s0_clk_q <= !s0_clk_q;
      // Outgoing data moves on the falling clock, LSB first
      if (s0_clk_q && s0_tx_q && s0_cnt_q != 3'd0)
        s0_sh_q <= {1'b1, s0_sh_q[7:1]};
      // Incoming data is taken on the rising clock
      if (!s0_clk_q)
      begin
        if (!s0_tx_q)
          s0_sh_q <= {rxd_s, s0_sh_q[7:1]};
        s0_cnt_q <= s0_cnt_q + 1'b1;
        if (s0_done)
          s0_busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive holding register, shared by both receive engines
  wire rx_done = arx_done || (s0_done && !s0_tx_q);
  usm_rxword_t rx_in;
  assign rx_in = arx_done ? arx_word : {1'b0, 1'b0, rxd_s, s0_sh_q[7:1]};
  assign tx_take = tx_start || s0_tx_go;

  // New word wins over a same-cycle read or clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      rx_hold_q <= '0;
      rx_valid_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        rx_hold_q <= rx_in;
        rx_valid_q <= 1'b1;
      end
      else if (rx_pop)
        rx_valid_q <= 1'b0;
      else if (stat_clr_fe)
        rx_hold_q.framing_err <= 1'b0;
      // Unread word overwritten: flag it
      if (rx_done && rx_valid_q && !rx_pop)
        overrun_q <= 1'b1;
      else if (stat_clr_ovr)
        overrun_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drive: txd carries the shift clock in shift mode
  assign o_txd = is_shift ? s0_clk_q : tx_sh_q[0];
  assign o_rxd = s0_sh_q[0];
  assign o_rxd_oe = is_shift && s0_busy_q && s0_tx_q;

endmodule

// ---- verif/usm_serial_port_props.sv ----
// Checker for the four-mode serial port: bus handshake and line timing.
// Assumes it is bound to usm_serial_port and sees only that module's ports.
`timescale 1ns/1ps
module usm_serial_port_props
  import usm_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Bus side
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Rate source and pins
  input wire logic i_t1_ovf,
  input wire logic i_rxd,
  input wire logic o_rxd,
  input wire logic o_rxd_oe,
  input wire logic o_txd
);
  // ==========================================================
  // Helper logic
  // Control bits as last written over the bus
  usm_ctrl_t ctrl_q;
  // Cycles txd has been low in the current stretch
  logic [11:0] low_q;
  // Decodes of the bus request
  wire logic mapped = (i_wb_adr == REG_CTRL) || (i_wb_adr == REG_STATUS) ||
    (i_wb_adr == REG_TXDATA) || (i_wb_adr == REG_RXDATA) || (i_wb_adr == REG_BRG);
  wire logic tx_wr = i_wb_we && (i_wb_adr == REG_TXDATA);
  wire logic ctrl_wr = o_wb_ack && i_wb_we && i_wb_sel[0] && (i_wb_adr == REG_CTRL);
  wire logic [1:0] cur_mode = {ctrl_q.mode_select_high, ctrl_q.mode_select_low};

  // Track control one cycle late; the bench never changes mode mid-frame
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      ctrl_q <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= i_wb_dat[4:0];
  end

  // Low-stretch counter, cleared while the line is high
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || o_txd)
      low_q <= '0;
    else
      low_q <= low_q + 12'h001;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_has_req_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without a bus request");
  ack_prompt_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !tx_wr |=> o_wb_ack)
    else $error("register access not answered next cycle");
  unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && !mapped |-> o_wb_dat == 32'h0)
    else $error("unmapped read returned nonzero");
  reset_idle_a: assert property ($past(i_srst) |-> o_txd && o_rxd && !o_rxd_oe && !o_wb_ack)
    else $error("pins not idle after reset");
  drive_shift_a: assert property (o_rxd_oe |-> cur_mode == MODE_SHIFT)
    else $error("receive pin driven outside shift mode");
  shift_half_a: assert property ($rose(o_txd) && cur_mode == MODE_SHIFT |-> low_q == 12'h003)
    else $error("shift clock low phase not three cycles");
  shift_hold_a: assert property ($rose(o_txd) && o_rxd_oe && $past(o_rxd_oe) |-> $stable(o_rxd))
    else $error("shift data moved at sampling edge");
  async_bit_a: assert property ($rose(o_txd) && cur_mode == MODE_UART9_FIX &&
    ctrl_q.rate_doubling_bit |-> low_q[3:0] == 4'h0 && low_q != 12'h000)
    else $error("fast fixed-rate low run not whole bits of 16");
endmodule

bind usm_serial_port usm_serial_port_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_t1_ovf(i_t1_ovf), .i_rxd(i_rxd),
  .o_rxd(o_rxd), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd)
);

// ---- verif/usm_serial_dev.sv ----
// Behavioural far-side serial device driving the port's receive line.
// Assumes a pull-up on the line, so it idles high between frames.
`timescale 1ns/1ps
module usm_serial_dev (
  // Clock
  input wire logic i_clk_sys,
  // Shift clock from the port, used in shift mode only
  input wire logic i_sclk,
  // Line toward the port
  output logic o_line
);
  // Pull-up level until the first frame
  initial o_line = 1'b1;

  // Short low pulse that must not pass for a start bit
  task automatic glitch(input int len);
    @(posedge i_clk_sys);
    o_line <= 1'b0;
    repeat (len) @(posedge i_clk_sys);
    o_line <= 1'b1;
  endtask

  // One frame, bit 0 first, each bit held for a whole period
  task automatic send(input logic [10:0] frame, input int nbits, input int period);
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge i_clk_sys);
      o_line <= frame[i];
      repeat (period - 1) @(posedge i_clk_sys);
    end
    // Back to the pull-up level
    @(posedge i_clk_sys);
    o_line <= 1'b1;
  endtask

  // Shift-mode partner: bit 0 at once, each next bit after a rising shift clock
  task automatic shift_out(input logic [7:0] b);
    logic [8:0] w;
    w = {1'b1, b};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge i_clk_sys);
      if (i > 0)
      begin
        while (i_sclk !== 1'b0) @(posedge i_clk_sys);
        while (i_sclk !== 1'b1) @(posedge i_clk_sys);
      end
      o_line <= w[i];
    end
  endtask
endmodule

// ---- verif/tb_usm_serial_port.sv ----
// Self-checking bench for the four-mode serial port.
// Assumes the checker is bound by its own file and the partner drives rxd.
`timescale 1ns/1ps
module tb_usm_serial_port;
  import usm_pkg::*;
  // ==========================================================
  // Signals
  localparam int DEPTH = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic t1_ovf = 1'b0;
  wire logic [31:0] rdat;
  wire logic ack, rxd_out, rxd_oe, txd, dev_line;
  // Shared pin: port drive wins while enabled, else the partner
  wire logic rxd_pin = rxd_oe ? rxd_out : dev_line;
  int n_mismatch = 0;
  int compares = 0;
  int cyc_cnt = 0;
  int t1_div = 0;

  always #2.5 clk = ~clk;

  usm_serial_port #(.FIFO_DEPTH(DEPTH)) uut (
    .i_clk_sys(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_t1_ovf(t1_ovf), .i_rxd(rxd_pin), .o_rxd(rxd_out), .o_rxd_oe(rxd_oe), .o_txd(txd)
  );
  usm_serial_dev dev (.i_clk_sys(clk), .i_sclk(txd), .o_line(dev_line));

  // Timer overflow every third cycle, plus the hang guard
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    t1_div <= (t1_div == 2) ? 0 : t1_div + 1;
    t1_ovf <= (t1_div == 2);
    if (cyc_cnt == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; held until ack is seen, no cycle count assumed
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Sample each line bit at its middle; returns at mid stop bit
  task automatic tx_check(input logic [10:0] f, input int nbits, input int period);
    while (txd !== 1'b0) @(posedge clk);
    repeat (period / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      if (i > 0)
        repeat (period) @(posedge clk);
      chk(32'(txd), 32'(f[i]));
    end
  endtask

  // One frame each way at once, receive preceded by a false start
  task automatic async_xfer(input logic [4:0] ctrl, input int nbits, input int period,
                            input logic [8:0] txw, input logic [8:0] rxw);
    wr(REG_CTRL, 32'(ctrl));
    wr(REG_TXDATA, 32'(txw));
    fork
      tx_check({1'b1, txw, 1'b0}, nbits, period);
      begin
        dev.glitch(period / 4);
        repeat (period) @(posedge clk);
        dev.send({1'b1, rxw, 1'b0}, nbits, period);
      end
    join
    repeat (2 * period) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0011);
    rd_chk(REG_RXDATA, 32'(rxw));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(REG_CTRL, 32'(CTRL_RESET));
    rd_chk(REG_BRG, 32'(BRG_RESET));
    rd_chk(REG_STATUS, 32'h0000_0010);
    wr(8'h20, 32'h0000_00FF);
    rd_chk(8'h20, 32'h0000_0000);
    chk(32'(txd), 32'h0000_0001);
  endtask

  // Rate bits set on purpose: shift timing must ignore them
  task automatic t_shift();
    int last;
    logic oe_v, pin_v;
    last = 0;
    wr(REG_CTRL, 32'h0000_000C);
    wr(REG_TXDATA, 32'h0000_00B4);
    for (int i = 0; i < 8; i++)
    begin
      while (txd !== 1'b0) @(posedge clk);
      // Pin as it stood at the rising edge; the port may release it right at that edge
      while (txd !== 1'b1)
      begin
        oe_v = rxd_oe;
        pin_v = rxd_pin;
        @(posedge clk);
      end
      chk(32'(oe_v), 32'h0000_0001);
      chk(32'(pin_v), (32'h0000_00B4 >> i) & 32'h0000_0001);
      if (i > 0)
        chk(32'(cyc_cnt - last), 32'(SHIFT_DIV));
      last = cyc_cnt;
    end
    repeat (12) @(posedge clk);
    chk(32'(rxd_oe), 32'h0000_0000);
    // Receive direction on the same pin; disable before reading so no new shift starts
    fork
      dev.shift_out(8'h69);
      wr(REG_CTRL, 32'h0000_001C);
    join
    wr(REG_CTRL, 32'h0000_000C);
    rd_chk(REG_STATUS, 32'h0000_0011);
    rd_chk(REG_RXDATA, 32'h0000_0069);
  endtask

  task automatic t_fixed_rate();
    async_xfer(5'h16, FRAME_BITS_9, 16, 9'h1A5, 9'h0C3);
    async_xfer(5'h12, FRAME_BITS_9, 32, 9'h05A, 9'h1F0);
  endtask

  // Overflow every 3 cycles: 16 ticks of 3 or 6 cycles per bit
  task automatic t_timer_rate();
    async_xfer(5'h11, FRAME_BITS_8, 96, 9'h13C, 9'h196);
    async_xfer(5'h15, FRAME_BITS_8, 48, 9'h1E1, 9'h100);
  endtask

  // Generator every 2 cycles, distinct from the timer source
  task automatic t_gen_rate();
    wr(REG_BRG, 32'h0000_0001);
    rd_chk(REG_BRG, 32'h0000_0001);
    async_xfer(5'h1B, FRAME_BITS_9, 64, 9'h0F7, 9'h155);
    async_xfer(5'h1F, FRAME_BITS_9, 32, 9'h108, 9'h02E);
  endtask

  // Overfill the queue while the line drains it slowly
  task automatic t_fifo();
    wr(REG_CTRL, 32'h0000_0006);
    fork
      begin
        for (int i = 0; i < DEPTH + 2; i++)
          wr(REG_TXDATA, 32'(9'(9'h101 + i * 7)));
        rd_chk(REG_STATUS, 32'h0000_0008);
      end
      for (int i = 0; i < DEPTH + 2; i++)
        tx_check({1'b1, 9'(9'h101 + i * 7), 1'b0}, FRAME_BITS_9, 16);
    join
    repeat (32) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0010);
  endtask

  // Low stop bit, then an unread word overwritten; both flags clear on a one
  task automatic t_errors();
    wr(REG_CTRL, 32'h0000_0016);
    dev.send(11'h0C6, FRAME_BITS_9, 16);
    repeat (32) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0015);
    dev.send(11'h4C6, FRAME_BITS_9, 16);
    repeat (32) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0013);
    wr(REG_STATUS, 32'h0000_0006);
    rd_chk(REG_STATUS, 32'h0000_0011);
    rd_chk(REG_RXDATA, 32'h0000_0063);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_shift();
    t_fixed_rate();
    t_timer_rate();
    t_gen_rate();
    t_fifo();
    t_errors();
    wrap_up();
  end
endmodule
